// File: rtl/adc_cmd_pkg.sv
// Purpose: shared constants and types of the adc serial command decoder
// Assumes: registers are eight bits wide and addressed by five bits
// Notes:   opcodes of the control group ignore bit 0
package adc_cmd_pkg;

  // -----------------------------------------------------------------------
  // register map
  // -----------------------------------------------------------------------
  localparam int REG_COUNT = 11;
  localparam logic [4:0] ADDR_IDENTITY_AND_OFFSET_CFG = 5'h00;
  localparam logic [4:0] ADDR_RATE_CFG = 5'h01;
  localparam logic [4:0] ADDR_GAIN_CFG = 5'h02;
  localparam logic [4:0] ADDR_HPF_LO = 5'h03;
  localparam logic [4:0] ADDR_HPF_HI = 5'h04;
  localparam logic [4:0] ADDR_OFC_LO = 5'h05;
  localparam logic [4:0] ADDR_OFC_MID = 5'h06;
  localparam logic [4:0] ADDR_OFC_HI = 5'h07;
  localparam logic [4:0] ADDR_FSC_LO = 5'h08;
  localparam logic [4:0] ADDR_FSC_MID = 5'h09;
  localparam logic [4:0] ADDR_FSC_HI = 5'h0a;
  localparam logic [4:0] ADDR_LAST = 5'h0a;

  localparam logic [7:0] RST_IDENTITY_AND_OFFSET_CFG = 8'h00;
  localparam logic [7:0] RST_RATE_CFG = 8'h52;
  localparam logic [7:0] RST_GAIN_CFG = 8'h08;
  localparam logic [7:0] RST_HPF_LO = 8'h32;
  localparam logic [7:0] RST_HPF_HI = 8'h03;
  localparam logic [7:0] RST_OFC = 8'h00;
  localparam logic [7:0] RST_FSC_LO = 8'h00;
  localparam logic [7:0] RST_FSC_MID = 8'h00;
  localparam logic [7:0] RST_FSC_HI = 8'h40;

  // offset injection field in the identity register, bits 1:0
  localparam int OFS_INJ_LSB = 0;
  localparam logic [1:0] OFS_INJ_100MV = 2'h2;
  localparam logic [1:0] OFS_INJ_75MV = 2'h3;

  // -----------------------------------------------------------------------
  // opcodes
  // -----------------------------------------------------------------------
  localparam logic [6:0] OP_WAKE = 7'h00;
  localparam logic [6:0] OP_STANDBY = 7'h01;
  localparam logic [6:0] OP_RESYNC = 7'h02;
  localparam logic [6:0] OP_REG_RESET = 7'h03;
  localparam logic [7:0] OP_CONT_READ = 8'h10;
  localparam logic [7:0] OP_STOP_CONT = 8'h11;
  localparam logic [7:0] OP_DATA_READ = 8'h12;
  localparam logic [2:0] OP_REG_READ = 3'h1;
  localparam logic [2:0] OP_REG_WRITE = 3'h2;
  localparam logic [7:0] OP_OFFSET_CAL = 8'h60;
  localparam logic [7:0] OP_GAIN_CAL = 8'h61;

  // -----------------------------------------------------------------------
  // counts
  // -----------------------------------------------------------------------
  localparam int CMD_GAP_CLKS = 24;
  localparam logic [5:0] WRITE_DISCARD = 6'h3f;
  localparam logic [4:0] CAL_LAST = 5'h0f;
  localparam logic [1:0] CONV_LAST_BYTE = 2'h3;

  typedef enum logic [3:0] {
    C_NONE, C_WAKE, C_STANDBY, C_RESYNC, C_RESET, C_CONT, C_STOP,
    C_DATA, C_REGISTER_READ_CMD, C_REGISTER_WRITE_CMD, C_OFFSET, C_GAIN
  } cmd_t;

endpackage

// File: rtl/bit_sync2.sv
// Purpose: two flip-flop synchroniser for levels and toggles
// Assumes: each bit changes slowly compared with the destination clock
// Notes:   the first stage is read only by the second
`timescale 1ns/1ps
module bit_sync2 #(
  parameter int WIDTH = 1
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);

  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] sync;
  } sync_t;

  sync_t r;
  sync_t r_nxt;

  always_comb begin
    r_nxt = r;
    r_nxt.meta = d;
    r_nxt.sync = r.meta;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      r <= '0;
    end else begin
      r <= r_nxt;
    end
  end

  assign q = r.sync;

endmodule

// File: rtl/serial_link_shifter.sv
// Purpose: serial shifter on the link clock, byte assembly and output
// Assumes: din sampled on rising edges, dout shifts on falling edges; each msb appears on the rising edge ending a byte
// Notes:   tx_word is held steady by the core across each byte
`timescale 1ns/1ps
module serial_link_shifter (
  input wire logic sclk,
  input wire logic rst,
  input wire logic cs_n,
  input wire logic din,
  input wire logic [7:0] tx_word,
  output logic [7:0] rx_byte,
  output logic rx_tgl,
  output logic dout
);

  typedef struct packed {
    logic [2:0] bit_cnt;
    logic [6:0] rx_sh;
  } frame_t;

  typedef struct packed {
    logic [7:0] rx_byte;
    logic rx_tgl;
  } hand_t;

  frame_t f_r;
  frame_t f_nxt;
  hand_t h_r;
  hand_t h_nxt;
  logic [7:0] tx_sh_r;
  logic [7:0] tx_sh_nxt;
  logic frame_rst;

  // the bit counter restarts on every deselect; the toggle must not,
  // or a deselect would look like a byte to the core
  assign frame_rst = rst | cs_n;

  always_comb begin
    f_nxt = f_r;
    h_nxt = h_r;
    f_nxt.bit_cnt = f_r.bit_cnt + 3'h1;
    f_nxt.rx_sh = {f_r.rx_sh[5:0], din};
    if (f_r.bit_cnt == 3'h7) begin
      h_nxt.rx_byte = {f_r.rx_sh, din};
      h_nxt.rx_tgl = ~h_r.rx_tgl;
    end
  end

  always_comb begin
    tx_sh_nxt = {tx_sh_r[6:0], 1'b0};
    if (f_r.bit_cnt == 3'h1) begin
      tx_sh_nxt = {tx_word[6:0], 1'b0};
    end
  end

  always_ff @(posedge sclk or posedge frame_rst) begin
    if (frame_rst) begin
      f_r <= '0;
    end else begin
      f_r <= f_nxt;
    end
  end

  always_ff @(posedge sclk or posedge rst) begin
    if (rst) begin
      h_r <= '0;
    end else begin
      h_r <= h_nxt;
    end
  end

  always_ff @(negedge sclk or posedge frame_rst) begin
    if (frame_rst) begin
      tx_sh_r <= '0;
    end else begin
      tx_sh_r <= tx_sh_nxt;
    end
  end

  // msb of a byte is presented as soon as the byte boundary is reached
  assign dout = (f_r.bit_cnt == 3'h0) ? tx_word[7] : tx_sh_r[7];
  assign rx_byte = h_r.rx_byte;
  assign rx_tgl = h_r.rx_tgl;

endmodule

// File: rtl/adc_serial_command_decoder.sv
// Purpose: serial command decoder and register file of a sigma-delta adc
// Assumes: conversions and gain calibration math live outside this block
// Notes:   serial shifting runs on sclk, decoding on ref_clk
// Notes on behaviour
// - control opcodes ignore bit 0: wake, standby, resync, register reset
// - 10h starts continuous read, 11h stops it, 12h reads one result
// - register read: 001 plus address, then 000 plus count minus one
// - register write: 010 plus address, then count minus one
// - a write takes one data byte per register, stored consecutively
// - 60h runs offset calibration, 61h runs gain calibration
// - chip select high cancels the stopped-read state
// - wake outside standby changes nothing
// - standby keeps registers and serial port; chip select or wake ends it
// - resync aborts the current conversion and restarts conversions
// - reset opcode restores defaults, continuous read and conversions
// - in continuous read a falling data ready marks fresh data
// - stopped read suppresses data ready and the data output
// - register data driven from 16th rising edge, sampled 17th rising
// - data output is released while chip select is high
// - every register write restarts conversions, losing 63 results
// - identity bits 7:4 are read only; host writes zero to bits 3:2
// - offset injection: 00 off, 01 reserved, 10 100mV, 11 75mV per gain
// - offset calibration averages 16 results with gain correction bypassed
`timescale 1ns/1ps
module adc_serial_command_decoder
  import adc_cmd_pkg::*;
#(
  parameter logic [3:0] IDENTITY_BITS = 4'h5 // arbitrary value
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic din,
  output logic dout,
  output logic dout_oe,
  output logic data_ready_n,
  input wire logic conv_valid,
  input wire logic [31:0] conv_data,
  output logic conv_restart,
  output logic standby,
  output logic gain_cal_start,
  output logic gain_bypass,
  input wire logic gain_cal_valid,
  input wire logic [23:0] gain_cal_word,
  output logic [7:0] rate_filter_config,
  output logic [7:0] input_gain_config,
  output logic [15:0] highpass_corner,
  output logic [23:0] offset_correction,
  output logic [23:0] gain_correction,
  output logic offset_inject_en,
  output logic offset_inject_75mv
);

  typedef enum logic [2:0] {S_IDLE, S_ARG, S_WR, S_RD, S_CONV} fsm_t;
  typedef enum logic {M_CONT, M_STOP} mode_t;
  typedef logic [REG_COUNT-1:0][7:0] regs_t;

  typedef struct packed {
    fsm_t st;
    mode_t mode;
    logic standby;
    logic wr;
    regs_t regs;
    logic [4:0] addr;
    logic [4:0] cnt;
    logic [31:0] conv;
    logic [1:0] conv_idx;
    logic data_ready_n_n;
    logic data_ready_n_pend;
    logic [5:0] discard;
    logic cal_run;
    logic [4:0] cal_cnt;
    logic [27:0] acc;
    logic restart;
    logic gain_start;
    logic [7:0] tx;
    logic drive;
    logic rx_d;
  } core_t;

  core_t q;
  core_t n;
  logic [7:0] rx_byte;
  logic rx_tgl;
  logic rx_tgl_s;
  logic cs_s;
  logic rx_evt;
  logic [27:0] acc_sum;
  cmd_t cmd;

  // -----------------------------------------------------------------------
  // helpers
  // -----------------------------------------------------------------------
  function automatic regs_t reg_defaults();
    regs_t r;
    r = '0;
    r[ADDR_IDENTITY_AND_OFFSET_CFG] = RST_IDENTITY_AND_OFFSET_CFG;
    r[ADDR_RATE_CFG] = RST_RATE_CFG;
    r[ADDR_GAIN_CFG] = RST_GAIN_CFG;
    r[ADDR_HPF_LO] = RST_HPF_LO;
    r[ADDR_HPF_HI] = RST_HPF_HI;
    r[ADDR_OFC_LO] = RST_OFC;
    r[ADDR_OFC_MID] = RST_OFC;
    r[ADDR_OFC_HI] = RST_OFC;
    r[ADDR_FSC_LO] = RST_FSC_LO;
    r[ADDR_FSC_MID] = RST_FSC_MID;
    r[ADDR_FSC_HI] = RST_FSC_HI;
    return r;
  endfunction

  function automatic logic [7:0] reg_read(regs_t r, logic [4:0] a);
    logic [7:0] v;
    v = 8'h00;
    if (a == ADDR_IDENTITY_AND_OFFSET_CFG) begin
      v = {IDENTITY_BITS, r[ADDR_IDENTITY_AND_OFFSET_CFG][3:0]};
    end else if (a <= ADDR_LAST) begin
      v = r[a];
    end
    return v;
  endfunction

  function automatic cmd_t decode_cmd(logic [7:0] b);
    cmd_t c;
    c = C_NONE;
    if (b[7:1] == OP_WAKE) begin
      c = C_WAKE;
    end else if (b[7:1] == OP_STANDBY) begin
      c = C_STANDBY;
    end else if (b[7:1] == OP_RESYNC) begin
      c = C_RESYNC;
    end else if (b[7:1] == OP_REG_RESET) begin
      c = C_RESET;
    end else if (b == OP_CONT_READ) begin
      c = C_CONT;
    end else if (b == OP_STOP_CONT) begin
      c = C_STOP;
    end else if (b == OP_DATA_READ) begin
      c = C_DATA;
    end else if (b[7:5] == OP_REG_READ) begin
      c = C_REGISTER_READ_CMD;
    end else if (b[7:5] == OP_REG_WRITE) begin
      c = C_REGISTER_WRITE_CMD;
    end else if (b == OP_OFFSET_CAL) begin
      c = C_OFFSET;
    end else if (b == OP_GAIN_CAL) begin
      c = C_GAIN;
    end
    return c;
  endfunction

  // -----------------------------------------------------------------------
  // link side and crossings
  // -----------------------------------------------------------------------
  serial_link_shifter u_link (
    .sclk(sclk),
    .rst(rst),
    .cs_n(cs_n),
    .din(din),
    .tx_word(q.tx),
    .rx_byte(rx_byte),
    .rx_tgl(rx_tgl),
    .dout(dout)
  );

  bit_sync2 #(.WIDTH(2)) u_sync (
    .clk(ref_clk),
    .rst(rst),
    .d({rx_tgl, cs_n}),
    .q({rx_tgl_s, cs_s})
  );

  // rx_byte is read without its own synchroniser: it loads on the same sclk
  // edge as the toggle, which then passes two flip-flops, and stays put until the next byte ends
  assign rx_evt = rx_tgl_s ^ q.rx_d;
  assign cmd = decode_cmd(rx_byte);
  assign acc_sum = q.acc + {{4{conv_data[31]}}, conv_data[31:8]};

  // -----------------------------------------------------------------------
  // next state
  // -----------------------------------------------------------------------
  always_comb begin
    n = q;
    n.restart = 1'b0;
    n.gain_start = 1'b0;
    n.data_ready_n_pend = 1'b0;
    n.rx_d = rx_tgl_s;
    if (q.data_ready_n_pend) begin
      n.data_ready_n_n = 1'b0;
    end
    if (conv_valid) begin
      if (q.discard != 6'h00) begin
        n.discard = q.discard - 6'h01;
      end else if (q.cal_run) begin
        n.acc = acc_sum;
        n.cal_cnt = q.cal_cnt + 5'h01;
        if (q.cal_cnt == CAL_LAST) begin
          n.cal_run = 1'b0;
          n.regs[ADDR_OFC_LO] = acc_sum[11:4];
          n.regs[ADDR_OFC_MID] = acc_sum[19:12];
          n.regs[ADDR_OFC_HI] = acc_sum[27:20];
        end
      end else if (q.st != S_CONV) begin
        n.conv = conv_data;
        n.conv_idx = 2'h0;
        if (q.mode == M_CONT) begin
          // brief high so every new result shows a fresh falling edge
          n.data_ready_n_n = 1'b1;
          n.data_ready_n_pend = 1'b1;
        end
      end
    end
    if (gain_cal_valid) begin
      n.regs[ADDR_FSC_LO] = gain_cal_word[7:0];
      n.regs[ADDR_FSC_MID] = gain_cal_word[15:8];
      n.regs[ADDR_FSC_HI] = gain_cal_word[23:16];
    end
    if (q.mode == M_STOP) begin
      n.data_ready_n_n = 1'b1;
      n.data_ready_n_pend = 1'b0;
    end

    if (cs_s) begin
      // a deselect drops any half-received command
      n.st = S_IDLE;
      n.standby = 1'b0;
      n.mode = M_CONT;
    end else if (rx_evt) begin
      case (q.st)
        S_IDLE: begin
          if (q.mode == M_CONT) begin
            n.conv_idx = q.conv_idx + 2'h1;
            if (!n.data_ready_n_pend) begin
              n.data_ready_n_n = 1'b1;
            end
          end
          case (cmd)
            C_WAKE: begin
              n.standby = 1'b0;
            end
            C_STANDBY: begin
              n.standby = 1'b1;
            end
            C_RESYNC: begin
              n.restart = 1'b1;
              n.data_ready_n_n = 1'b1;
              n.data_ready_n_pend = 1'b0;
            end
            C_RESET: begin
              n.regs = reg_defaults();
              n.mode = M_CONT;
              n.standby = 1'b0;
              n.restart = 1'b1;
              n.discard = 6'h00;
              n.cal_run = 1'b0;
              n.data_ready_n_n = 1'b1;
              n.data_ready_n_pend = 1'b0;
            end
            C_CONT: begin
              n.mode = M_CONT;
            end
            C_STOP: begin
              n.mode = M_STOP;
            end
            C_DATA: begin
              n.st = S_CONV;
              n.conv_idx = 2'h0;
            end
            C_REGISTER_READ_CMD: begin
              n.st = S_ARG;
              n.wr = 1'b0;
              n.addr = rx_byte[4:0];
            end
            C_REGISTER_WRITE_CMD: begin
              n.st = S_ARG;
              n.wr = 1'b1;
              n.addr = rx_byte[4:0];
            end
            C_OFFSET: begin
              n.cal_run = 1'b1;
              n.cal_cnt = 5'h00;
              n.acc = '0;
            end
            C_GAIN: begin
              n.gain_start = 1'b1;
            end
            default: begin
            end
          endcase
        end
        S_ARG: begin
          n.cnt = rx_byte[4:0];
          n.st = q.wr ? S_WR : S_RD;
        end
        S_WR: begin
          if (q.addr == ADDR_IDENTITY_AND_OFFSET_CFG) begin
            n.regs[ADDR_IDENTITY_AND_OFFSET_CFG] = {4'h0, rx_byte[3:0]};
          end else if (q.addr <= ADDR_LAST) begin
            n.regs[q.addr] = rx_byte;
          end
          n.restart = 1'b1;
          n.discard = WRITE_DISCARD;
          n.data_ready_n_n = 1'b1;
          n.data_ready_n_pend = 1'b0;
          n.addr = q.addr + 5'h01;
          n.cnt = q.cnt - 5'h01;
          if (q.cnt == 5'h00) begin
            n.st = S_IDLE;
          end
        end
        S_RD: begin
          n.addr = q.addr + 5'h01;
          n.cnt = q.cnt - 5'h01;
          if (q.cnt == 5'h00) begin
            n.st = S_IDLE;
          end
        end
        S_CONV: begin
          n.conv_idx = q.conv_idx + 2'h1;
          if (q.conv_idx == CONV_LAST_BYTE) begin
            n.st = S_IDLE;
          end
        end
        default: begin
          n.st = S_IDLE;
        end
      endcase
    end

    // byte to present next; read data is ready before byte two ends
    if (n.st == S_RD || (n.st == S_ARG && !n.wr)) begin
      n.tx = reg_read(n.regs, n.addr);
    end else begin
      n.tx = n.conv[8'd31 - {n.conv_idx, 3'h0} -: 8];
    end
    n.drive = (n.st == S_RD) || (n.st == S_ARG && !n.wr) ||
              (n.st == S_CONV) || (n.mode == M_CONT);
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      q <= '0;
      q.regs <= reg_defaults();
      q.data_ready_n_n <= 1'b1;
      q.mode <= M_CONT;
    end else begin
      q <= n;
    end
  end

  // -----------------------------------------------------------------------
  // outputs
  // -----------------------------------------------------------------------
  assign dout_oe = ~cs_n & q.drive;
  assign data_ready_n = q.data_ready_n_n;
  assign conv_restart = q.restart;
  assign standby = q.standby;
  assign gain_cal_start = q.gain_start;
  assign gain_bypass = q.cal_run;
  assign rate_filter_config = q.regs[ADDR_RATE_CFG];
  assign input_gain_config = q.regs[ADDR_GAIN_CFG];
  assign highpass_corner = {q.regs[ADDR_HPF_HI], q.regs[ADDR_HPF_LO]};
  assign offset_correction = {q.regs[ADDR_OFC_HI], q.regs[ADDR_OFC_MID],
                              q.regs[ADDR_OFC_LO]};
  assign gain_correction = {q.regs[ADDR_FSC_HI], q.regs[ADDR_FSC_MID],
                            q.regs[ADDR_FSC_LO]};
  // reserved code 01 leaves injection off
  assign offset_inject_en = q.regs[ADDR_IDENTITY_AND_OFFSET_CFG][OFS_INJ_LSB+1];
  assign offset_inject_75mv =
    (q.regs[ADDR_IDENTITY_AND_OFFSET_CFG][OFS_INJ_LSB+:2] == OFS_INJ_75MV);

  // -----------------------------------------------------------------------
  // checks
  // -----------------------------------------------------------------------
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);

  sequence s_cmd(cmd_t c);
    q.st == S_IDLE && rx_evt && !cs_s && cmd == c;
  endsequence
  sequence s_wr_byte;
    q.st == S_WR && rx_evt && !cs_s;
  endsequence
  sequence s_cal_last;
    q.cal_run && conv_valid && q.discard == 6'h00 && q.cal_cnt == CAL_LAST;
  endsequence

  AST_STANDBY_ENTER: assert property (
    s_cmd(C_STANDBY) |=> q.standby)
    else $error("standby opcode did not enter standby");
  AST_WAKE_NO_EFFECT: assert property (
    s_cmd(C_WAKE) ##0 !q.standby |=> !q.standby && $stable(q.mode))
    else $error("wake outside standby changed state");
  AST_CS_LEAVES_STANDBY: assert property (
    cs_s |=> !q.standby && q.mode == M_CONT && q.st == S_IDLE)
    else $error("deselect did not clear standby or stopped read");
  AST_RESYNC_RESTART: assert property (
    s_cmd(C_RESYNC) |=> conv_restart ##1 !conv_restart)
    else $error("resync did not pulse restart once");
  AST_RESET_DEFAULTS: assert property (
    s_cmd(C_RESET) |=> q.mode == M_CONT && conv_restart &&
      q.regs[ADDR_RATE_CFG] == RST_RATE_CFG &&
      q.regs[ADDR_FSC_HI] == RST_FSC_HI)
    else $error("reset opcode did not restore defaults");
  AST_WRITE_STORE: assert property (
    s_wr_byte ##0 (q.addr != ADDR_IDENTITY_AND_OFFSET_CFG && q.addr <= ADDR_LAST) |=>
      q.regs[$past(q.addr)] == $past(rx_byte) &&
      q.addr == $past(q.addr) + 5'h01)
    else $error("register write not stored or address not stepped");
  AST_WRITE_DISCARD: assert property (
    s_wr_byte |=> conv_restart && q.discard == WRITE_DISCARD)
    else $error("register write did not restart conversions");
  AST_STOP_SILENT: assert property (
    q.mode == M_STOP ##1 q.mode == M_STOP |-> data_ready_n)
    else $error("data ready active in stopped read");
  AST_RELEASE_OUT: assert property (
    cs_n |-> !dout_oe)
    else $error("data output driven while deselected");
  AST_READ_DATA: assert property (
    q.st == S_RD |-> q.tx == reg_read(q.regs, q.addr) &&
      (dout_oe || cs_n))
    else $error("register read byte wrong or not driven");
  AST_OFFSET_CAL_DONE: assert property (
    s_cal_last |=> !gain_bypass &&
      offset_correction == $past(acc_sum[27:4]))
    else $error("offset calibration average not stored");
  AST_DATA_READ: assert property (
    s_cmd(C_DATA) |=> q.st == S_CONV && q.conv_idx == 2'h0 && dout_oe |
      cs_n)
    else $error("data read opcode did not start output");

endmodule

// File: sim/host_model.sv
// Purpose: host side of the serial link, one byte per call
// Assumes: dout is read at sclk rising edges, msb first
// Notes:   sclk stands low between bytes and while cs_n is high
`timescale 1ns/1ps
module host_model (
  output logic sclk,
  output logic cs_n,
  output logic din,
  input wire logic dout
);
  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    din = 1'b0;
  end

  // the 400 ns tail keeps well over 24 master clocks between bytes
  task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
    cs_n = 1'b0;
    #100;
    for (int i = 7; i >= 0; i--) begin
      din = tx[i];
      #15 sclk = 1'b1;
      rx[i] = dout;
      #15 sclk = 1'b0;
    end
    #400;
  endtask

  // released data line toggles so a stale value is never read as good
  task automatic release_cs();
    cs_n = 1'b1;
    din = ~din;
    #200;
  endtask
endmodule

// File: sim/adc_serial_command_decoder_tb.sv
// Purpose: self-checking bench of the serial command decoder
// Assumes: host_model drives the link, this module the conversions
// Notes:   pulses and data ready falls are counted on ref_clk
`timescale 1ns/1ps
module adc_serial_command_decoder_tb
  import adc_cmd_pkg::*;
;
  localparam logic [3:0] ID = 4'ha; // arbitrary value
  logic ref_clk, rst, sclk, cs_n, din, dout, dout_oe, data_ready_n;
  logic conv_valid, conv_restart, standby, gain_cal_start, gain_bypass;
  logic gain_cal_valid, offset_inject_en, offset_inject_75mv;
  logic data_ready_n_q = 1'b1;
  logic [31:0] conv_data, word;
  logic [23:0] gain_cal_word, offset_correction, gain_correction;
  logic [7:0] rate_filter_config, input_gain_config, b, rb[0:10];
  logic [15:0] highpass_corner;
  int fail_count, n_tests, cyc, rc, gc, df, n0;
  logic [7:0] def[0:10] = '{{ID, 4'h0}, RST_RATE_CFG, RST_GAIN_CFG,
    RST_HPF_LO, RST_HPF_HI, RST_OFC, RST_OFC, RST_OFC, RST_FSC_LO,
    RST_FSC_MID, RST_FSC_HI};

  adc_serial_command_decoder #(
    .IDENTITY_BITS(ID)
  ) u_adc_serial_command_decoder (
    .ref_clk, .rst, .sclk, .cs_n, .din, .dout, .dout_oe, .data_ready_n,
    .conv_valid, .conv_data, .conv_restart, .standby, .gain_cal_start,
    .gain_bypass, .gain_cal_valid, .gain_cal_word, .rate_filter_config,
    .input_gain_config, .highpass_corner, .offset_correction,
    .gain_correction, .offset_inject_en, .offset_inject_75mv);
  // a released data line shows the inverse, so an undriven read fails
  host_model u_host_model (
    .sclk, .cs_n, .din, .dout(dout_oe ? dout : ~dout));

  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  always @(posedge ref_clk) begin
    cyc++;
    if (conv_restart === 1'b1)
      rc++;
    if (gain_cal_start === 1'b1)
      gc++;
    if (data_ready_n_q === 1'b1 && data_ready_n === 1'b0)
      df++;
    data_ready_n_q <= data_ready_n;
    if (cyc == 30000) begin
      fail_count++;
      close_out();
    end
  end

  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [31:0] got, exp);
    n_tests++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic put(input logic [7:0] v);
    u_host_model.xfer(v, b);
  endtask
  task automatic cmd(input logic [7:0] v);
    put(v);
    u_host_model.release_cs();
  endtask
  task automatic rdword();
    repeat (4) begin
      put(8'h00);
      word = {word[23:0], b};
    end
  endtask
  task automatic register_read_cmd(input logic [4:0] a, input int n);
    put(OP_STOP_CONT);
    put({OP_REG_READ, a});
    put(8'(n - 1));
    for (int i = 0; i < n; i++)
      u_host_model.xfer(8'h00, rb[i]);
    u_host_model.release_cs();
  endtask
  task automatic register_write_cmd(input logic [4:0] a, input logic [7:0] d[$]);
    put({OP_REG_WRITE, a});
    put(8'(d.size() - 1));
    foreach (d[i])
      put(d[i]);
    u_host_model.release_cs();
  endtask
  task automatic conv(input logic [31:0] d);
    @(posedge ref_clk);
    conv_valid <= 1'b1;
    conv_data <= d;
    @(posedge ref_clk);
    conv_valid <= 1'b0;
    repeat (5) @(posedge ref_clk);
  endtask
  task automatic close_out();
    $display("comparisons %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // sequence
  // ----------------------------------------------------------------
  initial begin
    rst = 1'b1;
    conv_valid = 1'b0;
    conv_data = '0;
    gain_cal_valid = 1'b0;
    gain_cal_word = '0;
    repeat (10) @(posedge ref_clk);
    rst <= 1'b0;
    repeat (5) @(posedge ref_clk);
    chk(dout_oe, 0);
    register_read_cmd(5'h00, 11);
    for (int i = 0; i < 11; i++)
      chk(rb[i], def[i]);
    $display("test reset values done");
    for (int k = 0; k < 4; k++) begin
      register_write_cmd(5'h00, '{8'hf0 | 8'(k)});
      chk(offset_inject_en, k[1]);
      chk(offset_inject_75mv, k == 3);
    end
    n0 = rc;
    register_write_cmd(5'h01, '{8'h5a, 8'h17, 8'hc4});
    chk(rc - n0, 3);
    chk({rate_filter_config, input_gain_config}, 16'h5a17);
    chk(highpass_corner, 16'h03c4);
    n0 = df;
    repeat (63) conv(32'h0);
    chk(df - n0, 0);
    conv(32'h89abcdef);
    chk(df - n0, 1);
    rdword();
    u_host_model.release_cs();
    chk(word, 32'h89abcdef);
    chk(standby, 0);
    register_read_cmd(5'h00, 4);
    chk({rb[0], rb[1], rb[2], rb[3]}, {ID, 28'h35a17c4});
    $display("test register write done");
    for (int k = 0; k < 2; k++) begin
      put({OP_STANDBY, k[0]});
      chk(standby, 1);
      put({OP_WAKE, k[0]});
      chk(standby, 0);
      cmd({OP_STANDBY, k[0]});
      chk(standby, 0);
      register_write_cmd(5'h01, '{8'h11});
      n0 = rc;
      put({OP_RESYNC, k[0]});
      chk(rc - n0, 1);
      cmd({OP_REG_RESET, k[0]});
      chk(rc - n0, 2);
      chk(rate_filter_config, RST_RATE_CFG);
    end
    $display("test control opcodes done");
    put(OP_STOP_CONT);
    chk(dout_oe, 0);
    n0 = df;
    conv(32'h13579bdf);
    chk(df - n0, 0);
    put(OP_DATA_READ);
    rdword();
    chk(word, 32'h13579bdf);
    put(OP_CONT_READ);
    conv(32'h0);
    chk(df - n0, 1);
    cmd(OP_STOP_CONT);
    conv(32'h0);
    chk(df - n0, 2);
    $display("test read modes done");
    cmd(OP_OFFSET_CAL);
    chk(gain_bypass, 1);
    for (int i = 0; i < 16; i++)
      conv({24'h000120 + 24'(6 * (i % 2)), 8'h00});
    chk(gain_bypass, 0);
    chk(offset_correction, 24'h000123);
    n0 = gc;
    cmd(OP_GAIN_CAL);
    chk(gc - n0, 1);
    @(posedge ref_clk);
    gain_cal_valid <= 1'b1;
    gain_cal_word <= 24'h3ffe01;
    @(posedge ref_clk);
    gain_cal_valid <= 1'b0;
    repeat (2) @(posedge ref_clk);
    chk(gain_correction, 24'h3ffe01);
    $display("test calibration done");
    close_out();
  end
endmodule
